//--- verilog/rgp_pkg.sv
/*
  Shared constants for the PHY-side reduced-pin gigabit interface block:
  speed codes, link clock half-periods, nibble layout, media pair codes
  and crossover timing.
  Assumes a single 50 MHz system clock.
*/
`default_nettype none
package rgp_pkg;
  localparam int CLK_MHZ = 50;
  // Speed selection as seen on i_speed
  localparam logic [1:0] SPEED_10 = 2'h0;
  localparam logic [1:0] SPEED_100 = 2'h1;
  localparam logic [1:0] SPEED_1000 = 2'h2;
  // Link clock half-periods in system cycles, scaled 125 : 25 : 2.5 MHz
  localparam logic [7:0] HALF_1000 = 8'h01;
  localparam logic [7:0] HALF_100 = 8'h05;
  localparam logic [7:0] HALF_10 = 8'h32;
  localparam int NIB_W = 4;
  localparam int BYTE_W = 8;
  // Signal pair codes driven per media pair
  localparam logic [1:0] PAIR_A = 2'h0;
  localparam logic [1:0] PAIR_B = 2'h1;
  localparam logic [1:0] PAIR_C = 2'h2;
  localparam logic [1:0] PAIR_D = 2'h3;
  // Crossover hunt: dwell per configuration while no link
  localparam int MDIX_DWELL_US = 60;
  localparam int MDIX_DWELL_CYC = MDIX_DWELL_US * CLK_MHZ;
  localparam int FIFO_DEPTH = 16;
  typedef enum logic [2:0] {
    RX_IDLE = 3'h1,
    RX_LOW = 3'h2,
    RX_HIGH = 3'h4
  } rgp_rxst_type;
endpackage
`default_nettype wire

//--- verilog/rgp_fifo.sv
/*
  Flip-flop FIFO with valid/ready on both sides and honest full/empty.
  Assumes one clock and a synchronous active-high reset.
*/
`default_nettype none
module rgp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;
  logic push;
  logic pop;

  assign o_in_ready = (cnt_ff != DEPTH[AW:0]);
  assign o_out_valid = (cnt_ff != '0);
  assign o_out_data = mem_ff[rd_ff];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_ff[wr_ff] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // rgp_fifo
`default_nettype wire

//--- verilog/rgp_phy_if.sv
/*
  PHY-side reduced-pin gigabit interface: serialises received bytes onto
  the receive clock/control/data pins, captures the transmit pins into
  bytes, and assigns signal pairs to media pairs with automatic crossover.
  Assumes the transmit pins are synchronous to i_clk and sampled by it;
  link clocks are modelled as levels toggled on system-clock enables.
*/
`default_nettype none
// Behaviour
// - PHY drives receive clock at 125, 25 or 2.5 MHz per speed (the code scales this to 25, 5 or 0.5 MHz of the 50 MHz clock).
// - Receive control carries data valid at receive clock rise.
// - Receive control carries valid/error derivative at receive clock fall.
// - Gigabit receive: low nibble at rise, high nibble at fall.
// - 10/100 receive: one nibble per receive clock, at rise.
// - Gigabit media pair 0 carries pair A straight, B crossed.
// - Gigabit media pair 1 carries pair B straight, A crossed.
// - Gigabit media pair 2 carries pair C straight, D crossed.
// - Gigabit media pair 3 carries pair D straight, C crossed.
// - 10/100 media pair 0 transmits straight, receives crossed.
// - 10/100 media pair 1 receives straight, transmits crossed.
// - 10/100 media pairs 2 and 3 stay unused.
// - Straight or crossed assignment is chosen automatically at all speeds.
module rgp_phy_if
  import rgp_pkg::*;
#(
  parameter int DWELL_CYC = rgp_pkg::MDIX_DWELL_CYC
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [1:0] i_speed,
  input wire logic i_link_up,
  input wire logic [3:0] i_pair_energy,
  input wire logic i_rx_valid,
  output logic o_rx_ready,
  input wire logic [rgp_pkg::BYTE_W-1:0] i_rx_data,
  input wire logic i_rx_err,
  output logic o_rx_clk,
  output logic o_rx_ctrl,
  output logic [rgp_pkg::NIB_W-1:0] o_rxd,
  input wire logic i_tx_clk,
  input wire logic i_tx_ctrl,
  input wire logic [rgp_pkg::NIB_W-1:0] i_txd,
  output logic o_tx_valid,
  output logic [rgp_pkg::BYTE_W-1:0] o_tx_data,
  output logic o_tx_en,
  output logic o_tx_err,
  output logic o_crossed,
  output logic [3:0] o_pair_tx_en,
  output logic [3:0] o_pair_rx_en,
  output logic [7:0] o_pair_sel
);
  import rgp_pkg::*;
  localparam int CW = $clog2(DWELL_CYC + 1);

  // Receive path: buffer, then serialise onto the link pins
  logic fifo_in_ready;
  logic fifo_valid;
  logic fifo_pop;
  logic [BYTE_W:0] fifo_word;
  logic [7:0] half_cnt_ff;
  logic [7:0] half_len;
  logic tick;
  logic gig;
  logic cur_dv_ff;
  logic cur_er_ff;
  logic [BYTE_W-1:0] cur_data_ff;
  logic nib_hi_ff;
  logic ready_ff;
  rgp_rxst_type rx_st_ff;

  rgp_fifo #(
    .WIDTH(BYTE_W + 1),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_in_valid(i_rx_valid && ready_ff),
    .o_in_ready(fifo_in_ready),
    .i_in_data({i_rx_err, i_rx_data}),
    .o_out_valid(fifo_valid),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_word)
  );

  // Ready is registered and gates the push, so a byte is taken only when
  // the source saw ready high; it drops for a cycle after each accept.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ready_ff <= 1'b0;
    end else begin
      ready_ff <= fifo_in_ready && !(i_rx_valid && ready_ff);
    end
  end
  assign o_rx_ready = ready_ff;

  assign gig = (i_speed == SPEED_1000);
  always_comb begin
    case (i_speed)
      SPEED_1000: half_len = HALF_1000;
      SPEED_100: half_len = HALF_100;
      default: half_len = HALF_10;
    endcase
  end
  assign tick = (half_cnt_ff >= half_len - 8'h01);
  // A new byte is fetched at a rising edge when the previous one is spent
  assign fifo_pop = tick && !o_rx_clk && (gig || !nib_hi_ff) && fifo_valid;

  // Clock divider: the receive clock runs free at the selected rate
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      half_cnt_ff <= 8'h00;
      o_rx_clk <= 1'b0;
    end else if (tick) begin
      half_cnt_ff <= 8'h00;
      o_rx_clk <= !o_rx_clk;
    end else begin
      half_cnt_ff <= half_cnt_ff + 8'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rx_st_ff <= RX_IDLE;
      cur_dv_ff <= 1'b0;
      cur_er_ff <= 1'b0;
      cur_data_ff <= '0;
      nib_hi_ff <= 1'b0;
      o_rx_ctrl <= 1'b0;
      o_rxd <= '0;
    end else if (tick) begin
      if (!o_rx_clk) begin
        // Rising edge of the receive clock
        if (gig || !nib_hi_ff) begin
          cur_dv_ff <= fifo_valid;
          cur_er_ff <= fifo_valid && fifo_word[BYTE_W];
          cur_data_ff <= fifo_valid ? fifo_word[BYTE_W-1:0] : '0;
          o_rx_ctrl <= fifo_valid;
          o_rxd <= fifo_valid ? fifo_word[NIB_W-1:0] : '0;
          nib_hi_ff <= !gig && fifo_valid;
          rx_st_ff <= fifo_valid ? RX_LOW : RX_IDLE;
        end else begin
          o_rx_ctrl <= cur_dv_ff;
          o_rxd <= cur_data_ff[BYTE_W-1:NIB_W];
          nib_hi_ff <= 1'b0;
          rx_st_ff <= RX_HIGH;
        end
      end else begin
        // Falling edge: derivative of valid and error
        o_rx_ctrl <= cur_dv_ff ^ cur_er_ff;
        if (gig) begin
          o_rxd <= cur_data_ff[BYTE_W-1:NIB_W];
          rx_st_ff <= cur_dv_ff ? RX_HIGH : RX_IDLE;
        end
      end
    end
  end

  // Transmit capture; the MAC keeps its own clock and edge discipline
  logic tx_clk_q_ff;
  logic tx_en_ff;
  logic tx_half_ff;
  logic [NIB_W-1:0] tx_lo_ff;
  logic tx_rise;
  logic tx_fall;

  assign tx_rise = i_tx_clk && !tx_clk_q_ff;
  assign tx_fall = !i_tx_clk && tx_clk_q_ff;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      tx_clk_q_ff <= 1'b0;
    end else begin
      tx_clk_q_ff <= i_tx_clk;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      tx_en_ff <= 1'b0;
      tx_half_ff <= 1'b0;
      tx_lo_ff <= '0;
      o_tx_valid <= 1'b0;
      o_tx_data <= '0;
      o_tx_en <= 1'b0;
      o_tx_err <= 1'b0;
    end else begin
      o_tx_valid <= 1'b0;
      if (tx_rise) begin
        tx_en_ff <= i_tx_ctrl;
        if (gig || !tx_half_ff || !i_tx_ctrl) begin
          tx_lo_ff <= i_txd;
          tx_half_ff <= !gig && i_tx_ctrl;
        end else begin
          o_tx_valid <= 1'b1;
          o_tx_data <= {i_txd, tx_lo_ff};
          o_tx_en <= 1'b1;
          tx_half_ff <= 1'b0;
        end
      end else if (tx_fall) begin
        o_tx_err <= tx_en_ff ^ i_tx_ctrl;
        if (gig) begin
          o_tx_valid <= 1'b1;
          o_tx_data <= {i_txd, tx_lo_ff};
          o_tx_en <= tx_en_ff;
        end
      end
    end
  end

  // Automatic crossover: hunt between configurations until link comes up or the receive pair shows energy
  logic [CW-1:0] dwell_ff;
  logic rx_pair_live;

  assign rx_pair_live = o_crossed ? i_pair_energy[0] : i_pair_energy[1];

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      dwell_ff <= '0;
      o_crossed <= 1'b0;
    end else if (i_link_up || rx_pair_live) begin
      dwell_ff <= '0;
    end else if (dwell_ff == CW'(DWELL_CYC - 1)) begin
      dwell_ff <= '0;
      o_crossed <= !o_crossed;
    end else begin
      dwell_ff <= dwell_ff + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_pair_tx_en <= 4'h0;
      o_pair_rx_en <= 4'h0;
      o_pair_sel <= 8'h00;
    end else if (gig) begin
      o_pair_tx_en <= 4'hf;
      o_pair_rx_en <= 4'hf;
      o_pair_sel[1:0] <= o_crossed ? PAIR_B : PAIR_A;
      o_pair_sel[3:2] <= o_crossed ? PAIR_A : PAIR_B;
      o_pair_sel[5:4] <= o_crossed ? PAIR_D : PAIR_C;
      o_pair_sel[7:6] <= o_crossed ? PAIR_C : PAIR_D;
    end else begin
      o_pair_tx_en <= {2'h0, o_crossed, !o_crossed};
      o_pair_rx_en <= {2'h0, !o_crossed, o_crossed};
      o_pair_sel[3:0] <= o_crossed ? {PAIR_A, PAIR_B} : {PAIR_B, PAIR_A};
      o_pair_sel[7:4] <= {PAIR_D, PAIR_C};
    end
  end
endmodule // rgp_phy_if
`default_nettype wire

//--- bench/rgp_chk.sv
/* Port-level assertions for rgp_phy_if.
   Assumes the bind at the foot reaches every rgp_phy_if instance. */
`default_nettype none
module rgp_chk
  import rgp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [1:0] i_speed,
  input wire logic i_link_up,
  input wire logic i_tx_clk,
  input wire logic o_rx_clk,
  input wire logic o_rx_ctrl,
  input wire logic [3:0] o_rxd,
  input wire logic o_tx_valid,
  input wire logic o_crossed,
  input wire logic [3:0] o_pair_tx_en,
  input wire logic [3:0] o_pair_rx_en,
  input wire logic [7:0] o_pair_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // Entering gigabit ends any slow half-period at once; the check still waits 63 cycles
  logic [5:0] gig_ff;
  always_ff @(posedge i_clk) begin
    if (i_srst || i_speed != SPEED_1000) begin
      gig_ff <= 6'h0;
    end else if (gig_ff != 6'h3f) begin
      gig_ff <= gig_ff + 6'h1;
    end
  end
  clk_gig_a: assert property (gig_ff == 6'h3f |-> o_rx_clk != $past(o_rx_clk))
    else $error("receive clock stalled at gigabit");
  tx_pulse_a: assert property (o_tx_valid |=> !o_tx_valid)
    else $error("tx valid longer than one cycle");
  tx_fall_a: assert property (o_tx_valid && i_speed == SPEED_1000 |->
    ($past(i_tx_clk, 2) && !$past(i_tx_clk)) || ($past(i_tx_clk, 3) && !$past(i_tx_clk, 2))
    || ($past(i_tx_clk, 4) && !$past(i_tx_clk, 3))) else $error("tx byte without falling edge");
  sel_straight_a: assert property (i_speed == SPEED_1000 && $stable(i_speed) &&
    !o_crossed && $stable(o_crossed) && !$past(i_srst) |-> o_pair_sel == 8'he4)
    else $error("straight pair map wrong");
  sel_crossed_a: assert property (i_speed == SPEED_1000 && $stable(i_speed) &&
    o_crossed && $stable(o_crossed) && !$past(i_srst) |-> o_pair_sel == 8'hb1)
    else $error("crossed pair map wrong");
  slow_pairs_a: assert property (i_speed != SPEED_1000 && $stable(i_speed) &&
    $stable(o_crossed) && !$past(i_srst) |-> o_pair_tx_en == (o_crossed ? 4'h2 : 4'h1)
    && o_pair_rx_en == (o_crossed ? 4'h1 : 4'h2)) else $error("slow pair use wrong");
  pin_edge_a: assert property (!$past(i_srst) && $changed({o_rxd, o_rx_ctrl}) |->
    $changed(o_rx_clk)) else $error("receive pins moved off a clock toggle");
  idle_zero_a: assert property ($rose(o_rx_clk) && !o_rx_ctrl |-> o_rxd == 4'h0)
    else $error("data without valid");
  link_hold_a: assert property (i_link_up && $past(i_link_up) && !$past(i_srst) |->
    $stable(o_crossed)) else $error("crossover moved with link up");
  cover property (o_tx_valid);
  cover property ($rose(o_crossed));
  cover property ($rose(o_rx_clk) && o_rx_ctrl);
endmodule // rgp_chk
bind rgp_phy_if rgp_chk u_chk (.i_clk(i_clk), .i_srst(i_srst), .i_speed(i_speed),
  .i_link_up(i_link_up), .i_tx_clk(i_tx_clk), .o_rx_clk(o_rx_clk), .o_rx_ctrl(o_rx_ctrl),
  .o_rxd(o_rxd), .o_tx_valid(o_tx_valid), .o_crossed(o_crossed), .o_pair_tx_en(o_pair_tx_en),
  .o_pair_rx_en(o_pair_rx_en), .o_pair_sel(o_pair_sel));
`default_nettype wire

//--- bench/rgp_mac_model.sv
/* Behavioural MAC driving the transmit pins of rgp_phy_if.
   Assumes the pins are sampled by the same system clock. */
`default_nettype none
module rgp_mac_model (
  input wire logic i_clk,
  output logic o_tx_clk,
  output logic o_tx_ctrl,
  output logic [3:0] o_txd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_tx_clk = 1'b0;
    o_tx_ctrl = 1'b0;
    o_txd = 4'h0;
  end
  // Two cycles a half period; the capture side accepts as few as one
  task automatic half(input logic c, input logic ctl, input logic [3:0] d);
    @(posedge i_clk);
    o_tx_clk <= c;
    o_tx_ctrl <= ctl;
    o_txd <= d;
    @(posedge i_clk);
  endtask
  task automatic send(input logic [7:0] b, input logic en, input logic er, input logic gig);
    half(1'b1, en, b[3:0]);
    half(1'b0, en ^ er, gig ? b[7:4] : ~b[3:0]);
    if (!gig) begin
      half(1'b1, en, b[7:4]);
      half(1'b0, en ^ er, ~b[7:4]);
    end
    // Clock rests low between frames; data shows no stale nibble
    half(1'b0, 1'b0, ~o_txd);
  endtask
endmodule // rgp_mac_model
`default_nettype wire

//--- bench/rgp_phy_if_bench.sv
/* Self-checking bench for rgp_phy_if with a MAC model on the transmit pins.
   Assumes a shortened crossover dwell. */
`default_nettype none
module rgp_phy_if_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import rgp_pkg::*;
  localparam int DWELL = 20;
  logic i_clk, i_srst, i_link_up, i_rx_valid, i_rx_err, o_rx_ready, o_rx_clk, o_rx_ctrl;
  logic tx_clk, tx_ctrl, o_tx_valid, o_tx_en, o_tx_err, o_crossed;
  logic [1:0] i_speed;
  logic [3:0] i_pair_energy, o_rxd, txd, o_pair_tx_en, o_pair_rx_en;
  logic [7:0] i_rx_data, o_tx_data, o_pair_sel;
  int err_total = 0;
  int tests_run = 0;
  rgp_phy_if #(.DWELL_CYC(DWELL)) dut (.i_clk(i_clk), .i_srst(i_srst), .i_speed(i_speed),
    .i_link_up(i_link_up), .i_pair_energy(i_pair_energy), .i_rx_valid(i_rx_valid),
    .o_rx_ready(o_rx_ready), .i_rx_data(i_rx_data), .i_rx_err(i_rx_err), .o_rx_clk(o_rx_clk),
    .o_rx_ctrl(o_rx_ctrl), .o_rxd(o_rxd), .i_tx_clk(tx_clk), .i_tx_ctrl(tx_ctrl), .i_txd(txd),
    .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .o_tx_en(o_tx_en), .o_tx_err(o_tx_err),
    .o_crossed(o_crossed), .o_pair_tx_en(o_pair_tx_en), .o_pair_rx_en(o_pair_rx_en),
    .o_pair_sel(o_pair_sel));
  rgp_mac_model mac (.i_clk(i_clk), .o_tx_clk(tx_clk), .o_tx_ctrl(tx_ctrl), .o_txd(txd));
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  task automatic cmp_bit(input string n, input logic s, input logic e);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cmp_val(input string n, input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic results();
    $display("Checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic tick();
    logic p;
    int n;
    p = o_rx_clk;
    n = 0;
    while (o_rx_clk === p && n < 120) begin
      @(negedge i_clk);
      n++;
    end
    if (n == 120) err_total++;
  endtask
  task automatic push(input logic [7:0] b, input logic e);
    @(posedge i_clk);
    i_rx_valid <= 1'b1;
    i_rx_data <= b;
    i_rx_err <= e;
    do @(posedge i_clk); while (o_rx_ready !== 1'b1);
    i_rx_valid <= 1'b0;
  endtask
  task automatic t_rx(input logic [1:0] sp);
    logic [7:0] b;
    int n;
    @(posedge i_clk);
    i_speed <= sp;
    for (int k = 0; k < 2; k++) begin
      b = k[0] ? 8'h3c : 8'ha5;
      push(b, k[0]);
      n = 0;
      do begin
        tick();
        n++;
      end while (!(o_rx_clk === 1'b1 && o_rx_ctrl === 1'b1) && n < 8);
      cmp_val("rxd_low", {4'h0, o_rxd}, {4'h0, b[3:0]});
      tick();
      cmp_bit("ctrl_fall", o_rx_ctrl, ~k[0]);
      if (sp != SPEED_1000) tick();
      cmp_val("rxd_high", {4'h0, o_rxd}, {4'h0, b[7:4]});
    end
    $display("rx test done speed %0d", sp);
  endtask
  task automatic t_tx(input logic [1:0] sp, input logic [7:0] b, input logic er);
    int n;
    @(posedge i_clk);
    i_speed <= sp;
    fork
      mac.send(b, 1'b1, er, sp == SPEED_1000);
      begin
        n = 0;
        do begin
          @(negedge i_clk);
          n++;
        end while (o_tx_valid !== 1'b1 && n < 40);
        cmp_val("tx_data", o_tx_data, b);
        cmp_bit("tx_en", o_tx_en, 1'b1);
        cmp_bit("tx_err", o_tx_err, er);
      end
    join
    $display("tx test done speed %0d", sp);
  endtask
  task automatic t_fill();
    int acc;
    acc = 0;
    @(posedge i_clk);
    i_speed <= SPEED_10;
    // Start just after a slow rising edge so no byte drains inside the window
    tick();
    tick();
    while (o_rx_clk !== 1'b1) tick();
    @(posedge i_clk);
    i_rx_valid <= 1'b1;
    repeat (60) begin
      @(posedge i_clk);
      if (o_rx_ready === 1'b1) acc++;
    end
    i_rx_valid <= 1'b0;
    @(negedge i_clk);
    cmp_bit("ready_full", o_rx_ready, 1'b0);
    cmp_bit("fifo_depth", acc >= FIFO_DEPTH, 1'b1);
    // Reset mid-stream discards the slow backlog instead of draining it
    @(posedge i_clk);
    i_srst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_srst <= 1'b0;
    repeat (3) @(negedge i_clk);
    cmp_bit("ready_reset", o_rx_ready, 1'b1);
    $display("fifo test done");
  endtask
  task automatic t_mdix();
    logic c;
    int n;
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clk);
      i_speed <= k[1] ? SPEED_100 : SPEED_1000;
      i_link_up <= 1'b0;
      c = o_crossed;
      n = 0;
      do begin
        @(negedge i_clk);
        n++;
      end while (o_crossed === c && n < 3 * DWELL);
      cmp_bit("hunt_toggle", o_crossed, ~c);
      @(posedge i_clk);
      i_link_up <= 1'b1;
      repeat (3 * DWELL) @(negedge i_clk);
      cmp_bit("link_hold", o_crossed, ~c);
      if (k[1]) begin
        cmp_val("pair_tx", {4'h0, o_pair_tx_en}, c ? 8'h01 : 8'h02);
        cmp_val("pair_rx", {4'h0, o_pair_rx_en}, c ? 8'h02 : 8'h01);
      end else begin
        cmp_val("pair_sel", o_pair_sel, c ? 8'he4 : 8'hb1);
      end
    end
    @(posedge i_clk);
    i_pair_energy <= o_crossed ? 4'h1 : 4'h2;
    i_link_up <= 1'b0;
    c = o_crossed;
    repeat (3 * DWELL) @(negedge i_clk);
    cmp_bit("energy_hold", o_crossed, c);
    $display("crossover test done");
  endtask
  initial begin
    i_srst = 1'b1;
    i_speed = SPEED_1000;
    i_link_up = 1'b1;
    i_pair_energy = 4'h0;
    i_rx_valid = 1'b0;
    i_rx_data = 8'h5a;
    i_rx_err = 1'b0;
    repeat (6) @(posedge i_clk);
    i_srst <= 1'b0;
    t_rx(SPEED_1000);
    t_rx(SPEED_100);
    t_rx(SPEED_10);
    t_tx(SPEED_1000, 8'hc3, 1'b0);
    t_tx(SPEED_1000, 8'h96, 1'b1);
    t_tx(SPEED_100, 8'h7e, 1'b0);
    t_tx(SPEED_10, 8'h81, 1'b1);
    t_fill();
    t_mdix();
    results();
  end
  initial begin
    repeat (30000) @(posedge i_clk);
    err_total++;
    results();
  end
endmodule // rgp_phy_if_bench
`default_nettype wire
